// >>> hdl/uart_pkg.sv
// Package holding register offsets, field positions and reset values of the serial port.
package uart_pkg;

	// Word offsets of the registers on the Avalon-MM bus.
	localparam logic [3:0] OFS_CTRL_ONE = 4'h0;
	localparam logic [3:0] OFS_CTRL_TWO = 4'h1;
	localparam logic [3:0] OFS_CTRL_THREE = 4'h2;
	localparam logic [3:0] OFS_DIVISOR = 4'h3;
	localparam logic [3:0] OFS_DATA = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h5;
	localparam logic [3:0] OFS_MODE = 4'h6;

	// Field positions in the first control register.
	localparam int CR1_PORT_ENABLE = 7;
	localparam int CR1_NINE_BIT = 6;
	localparam int CR1_PARITY_ENABLE = 5;
	localparam int CR1_PARITY_TYPE = 4;
	localparam int CR1_STOP_COUNT = 3;
	localparam int CR1_SEND_BREAK = 2;
	localparam int CR1_TX_BIT_NINE = 0;

	// Field positions in the second control register.
	localparam int CR2_TX_ENABLE = 7;
	localparam int CR2_RX_ENABLE = 6;
	localparam int CR2_SPEED_SELECT = 5;
	localparam int CR2_ADDR_DETECT = 4;

	// Field positions in the status register.
	localparam int ST_PARITY_ERR = 7;
	localparam int ST_NOISE = 6;
	localparam int ST_FRAMING_ERR = 5;
	localparam int ST_OVERRUN = 4;
	localparam int ST_RX_IDLE = 3;
	localparam int ST_RX_AVAIL = 2;
	localparam int ST_TX_IDLE = 1;
	localparam int ST_TX_EMPTY = 0;

	// Reset values: 8 data bits, no parity, one stop bit, everything off.
	localparam logic [7:0] CR1_RESET = 8'h00;
	localparam logic [7:0] CR2_RESET = 8'h00;
	localparam logic [7:0] CR3_RESET = 8'h00;
	localparam logic [7:0] DIVISOR_RESET = 8'h00;
	localparam logic [7:0] STATUS_RESET = 8'h0b;
	localparam logic [7:0] MODE_RESET = 8'h00;

	// Last tick index of a bit in each speed mode, one less than the ticks per bit.
	localparam logic [5:0] TICKS_LOW_SPEED = 6'h3f;
	localparam logic [5:0] TICKS_HIGH_SPEED = 6'h0f;

	// Value of the serial-mode select that hands the pins to the port.
	localparam logic [7:0] SERIAL_MODE_PORT = 8'h01;

	// Value returned for unmapped addresses.
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// Transmitter state machine.
	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_START = 4'b0010,
		TX_DATA = 4'b0100,
		TX_STOP = 4'b1000
	} tx_state_t;

endpackage : uart_pkg

// >>> hdl/baud_tick_gen.sv
// Divisor timer producing sub-bit ticks and one bit strobe per bit time.
`timescale 1ns/1ps

module baud_tick_gen #(
	parameter int DIV_WIDTH = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [DIV_WIDTH-1:0] divisor,
	input wire logic speedSelect,
	input wire logic restart,
	output logic bitStrobe
);

	// Down-counter of the divisor timer, held at the divisor while restart is set.
	logic [DIV_WIDTH-1:0] timer_reg;
	// Count of sub-bit ticks inside the current bit.
	logic [5:0] tickCount_reg;
	// One-cycle tick at each timer wrap.
	logic subTick;
	// Last tick index of a bit for the current speed.
	logic [5:0] lastTick;

	assign subTick = (timer_reg == '0);
	assign lastTick = speedSelect ? uart_pkg::TICKS_HIGH_SPEED : uart_pkg::TICKS_LOW_SPEED;

	// The timer reloads from the divisor at terminal count, so N+1 clocks per tick.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			timer_reg <= '0;
		else if (restart || subTick)
			timer_reg <= divisor;
		else
			timer_reg <= timer_reg - 1'b1;
	end

	// Sixteen or sixty-four ticks make one bit, giving fH/(16 or 64)(N+1).
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			tickCount_reg <= '0;
		else if (restart)
			tickCount_reg <= '0;
		else if (subTick)
			tickCount_reg <= (tickCount_reg >= lastTick) ? 6'h00 : tickCount_reg + 6'h01;
	end

	// Bit strobe is a one-cycle pulse at the last tick of a bit.
	assign bitStrobe = subTick && (tickCount_reg >= lastTick) && !restart;

endmodule : baud_tick_gen

// >>> hdl/uart_tx_port.sv
// Serial port: register file, bit-rate generator and transmitter with holding and shift registers.
//
// The Avalon-MM register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module uart_tx_port #(
	parameter int DIV_WIDTH = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	output logic serialOutPin,
	output logic serialOutEnable,
	input wire logic serialInPin,
	output logic serialInOwned,
	output logic rxEnabled
);

	// Control registers, divisor, holding register, status and mode.
	logic [7:0] ctrlRegOne_reg;
	logic [7:0] ctrlRegTwo_reg;
	logic [7:0] ctrlRegThree_reg;
	logic [DIV_WIDTH-1:0] baudDivisor_reg;
	logic [7:0] dataHolding_reg;
	logic [7:0] status_reg;
	logic [7:0] serialModeSelect_reg;
	// Holding register contains a byte waiting for the shifter.
	logic holdingFull_reg;
	// Read data register and the one-cycle answer phase.
	logic [31:0] readData_reg;
	logic answer_reg;

	// Transmitter state.
	uart_pkg::tx_state_t txState_reg;
	logic [8:0] txShift_reg;
	logic [3:0] bitCount_reg;
	logic stopCount_reg;
	logic serialOut_reg;

	// Decoded controls.
	logic portEnable;
	logic txEnable;
	logic serialModeOn;
	logic txActive;
	logic nineBit;
	logic parityEnable;
	logic addressDetect;
	logic bitStrobe;
	logic restartTimer;
	logic accessEdge;
	logic dataWrite;
	logic shifterFree;
	logic loadShifter;
	// Last stop bit of a frame is being sent and ends at this edge.
	logic frameEnd;
	logic disableEvent;
	logic [8:0] frameBits;
	logic [3:0] dataBitCount;

	// Parity of the payload bits; even parity makes the total even.
	function automatic logic payload_parity(input logic [8:0] bits, input logic nine, input logic oddType);
		logic p;
		p = ^bits[7:0];
		if (!nine)
			p = ^bits[6:0];
		payload_parity = p ^ oddType;
	endfunction : payload_parity

	// Register writes take effect in the answer cycle only.
	assign accessEdge = answer_reg;
	assign waitrequest = (read || write) && !answer_reg;
	assign readdata = readData_reg;

	assign portEnable = ctrlRegOne_reg[uart_pkg::CR1_PORT_ENABLE];
	assign txEnable = ctrlRegTwo_reg[uart_pkg::CR2_TX_ENABLE];
	assign nineBit = ctrlRegOne_reg[uart_pkg::CR1_NINE_BIT];
	assign parityEnable = ctrlRegOne_reg[uart_pkg::CR1_PARITY_ENABLE];
	assign addressDetect = ctrlRegTwo_reg[uart_pkg::CR2_ADDR_DETECT];
	assign serialModeOn = (serialModeSelect_reg == uart_pkg::SERIAL_MODE_PORT);
	// Transmitter drives only when mode and both enables are set.
	assign txActive = serialModeOn && portEnable && txEnable;
	// A write of zero to port enable is the disable event.
	assign disableEvent = write && accessEdge && (address == uart_pkg::OFS_CTRL_ONE) &&
		!writedata[uart_pkg::CR1_PORT_ENABLE] && portEnable;
	assign dataWrite = write && accessEdge && (address == uart_pkg::OFS_DATA) && portEnable;
	assign shifterFree = (txState_reg == uart_pkg::TX_IDLE);
	// At the end of the last stop bit a pending byte moves into the shifter.
	assign frameEnd = (txState_reg == uart_pkg::TX_STOP) && bitStrobe && !stopCount_reg;
	// Data may be loaded before enabling; the shifter takes it once enabled.
	assign loadShifter = txActive &&
		((shifterFree && (holdingFull_reg || dataWrite)) || (frameEnd && holdingFull_reg));
	// Restarting on the load edge too keeps the start bit exactly one bit time long.
	assign restartTimer = !txActive || shifterFree;
	assign dataBitCount = nineBit ? 4'h9 : 4'h8;

	// Frame payload with optional parity or address bit in the last position.
	always_comb
	begin
		logic [7:0] src;
		src = dataWrite && !holdingFull_reg ? writedata[7:0] : dataHolding_reg;
		frameBits = {ctrlRegOne_reg[uart_pkg::CR1_TX_BIT_NINE], src};
		if (parityEnable)
		begin
			if (nineBit)
				frameBits[8] = payload_parity(frameBits, 1'b1, ctrlRegOne_reg[uart_pkg::CR1_PARITY_TYPE]);
			else
				frameBits[7] = payload_parity(frameBits, 1'b0, ctrlRegOne_reg[uart_pkg::CR1_PARITY_TYPE]);
		end
		else if (addressDetect && !nineBit)
			frameBits[7] = src[7];
	end

	baud_tick_gen #(
		.DIV_WIDTH(DIV_WIDTH)
	) u_baud (
		.clk(clk),
		.reset(reset),
		.divisor(baudDivisor_reg),
		.speedSelect(ctrlRegTwo_reg[uart_pkg::CR2_SPEED_SELECT]),
		.restart(restartTimer),
		.bitStrobe(bitStrobe)
	);

	// The bus answers one cycle after a request appears, then drops waitrequest.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			answer_reg <= 1'b0;
		else
			answer_reg <= (read || write) && !answer_reg;
	end

	// Read data are registered; unmapped addresses read zero.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			readData_reg <= uart_pkg::UNMAPPED_READ;
		else if (read && !answer_reg)
		begin
			case (address)
				uart_pkg::OFS_CTRL_ONE: readData_reg <= {24'h00_0000, ctrlRegOne_reg};
				uart_pkg::OFS_CTRL_TWO: readData_reg <= {24'h00_0000, ctrlRegTwo_reg};
				uart_pkg::OFS_CTRL_THREE: readData_reg <= {24'h00_0000, ctrlRegThree_reg};
				uart_pkg::OFS_DIVISOR: readData_reg <= {{(32-DIV_WIDTH){1'b0}}, baudDivisor_reg};
				uart_pkg::OFS_DATA: readData_reg <= {24'h00_0000, dataHolding_reg};
				uart_pkg::OFS_STATUS: readData_reg <= {24'h00_0000, status_reg};
				uart_pkg::OFS_MODE: readData_reg <= {24'h00_0000, serialModeSelect_reg};
				default: readData_reg <= uart_pkg::UNMAPPED_READ;
			endcase
		end
	end

	// First control register; a disable clears send-break, others keep their value.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			ctrlRegOne_reg <= uart_pkg::CR1_RESET;
		else if (write && accessEdge && address == uart_pkg::OFS_CTRL_ONE)
		begin
			ctrlRegOne_reg <= writedata[7:0];
			if (!writedata[uart_pkg::CR1_PORT_ENABLE])
				ctrlRegOne_reg[uart_pkg::CR1_SEND_BREAK] <= 1'b0;
		end
		else if (!portEnable)
			ctrlRegOne_reg[uart_pkg::CR1_SEND_BREAK] <= 1'b0;
	end

	// Second control register; while disabled, both enables stay cleared.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			ctrlRegTwo_reg <= uart_pkg::CR2_RESET;
		else
		begin
			if (write && accessEdge && address == uart_pkg::OFS_CTRL_TWO)
				ctrlRegTwo_reg <= writedata[7:0];
			if (disableEvent || (!portEnable &&
				!(write && accessEdge && address == uart_pkg::OFS_CTRL_ONE && writedata[uart_pkg::CR1_PORT_ENABLE])))
			begin
				ctrlRegTwo_reg[uart_pkg::CR2_TX_ENABLE] <= 1'b0;
				ctrlRegTwo_reg[uart_pkg::CR2_RX_ENABLE] <= 1'b0;
			end
		end
	end

	// Third control register, divisor and mode select keep their value across a disable.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ctrlRegThree_reg <= uart_pkg::CR3_RESET;
			baudDivisor_reg <= uart_pkg::DIVISOR_RESET;
			serialModeSelect_reg <= uart_pkg::MODE_RESET;
		end
		else if (write && accessEdge)
		begin
			if (address == uart_pkg::OFS_CTRL_THREE)
				ctrlRegThree_reg <= {7'h00, writedata[0]};
			if (address == uart_pkg::OFS_DIVISOR)
				baudDivisor_reg <= writedata[DIV_WIDTH-1:0];
			if (address == uart_pkg::OFS_MODE)
				serialModeSelect_reg <= writedata[7:0];
		end
	end

	// Holding register: a write goes to the shifter when it is free and the transmitter is active, else waits here.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			dataHolding_reg <= 8'h00;
			holdingFull_reg <= 1'b0;
		end
		else if (!portEnable || disableEvent)
			holdingFull_reg <= 1'b0;
		else
		begin
			if (dataWrite)
				dataHolding_reg <= writedata[7:0];
			if (loadShifter && !(dataWrite && holdingFull_reg))
				holdingFull_reg <= 1'b0;
			else if (dataWrite)
				holdingFull_reg <= 1'b1;
		end
	end

	// Status flags: disable clears errors and sets the idle and empty flags.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			status_reg <= uart_pkg::STATUS_RESET;
		else if (!portEnable || disableEvent)
		begin
			status_reg <= 8'h00;
			status_reg[uart_pkg::ST_TX_IDLE] <= 1'b1;
			status_reg[uart_pkg::ST_TX_EMPTY] <= 1'b1;
			status_reg[uart_pkg::ST_RX_IDLE] <= 1'b1;
		end
		else
		begin
			// Frame end with no byte pending sets idle; a new frame clears it, and the set wins.
			if (txState_reg == uart_pkg::TX_STOP && bitStrobe && !stopCount_reg && !holdingFull_reg)
				status_reg[uart_pkg::ST_TX_IDLE] <= 1'b1;
			else if (dataWrite || loadShifter)
				status_reg[uart_pkg::ST_TX_IDLE] <= 1'b0;
			// Empty reflects the holding register after this edge.
			if (dataWrite && !(loadShifter && !holdingFull_reg))
				status_reg[uart_pkg::ST_TX_EMPTY] <= 1'b0;
			else if (loadShifter || !holdingFull_reg)
				status_reg[uart_pkg::ST_TX_EMPTY] <= 1'b1;
		end
	end

	// Transmitter sequencer: start, data LSB first, then one or two stop bits.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			txState_reg <= uart_pkg::TX_IDLE;
			txShift_reg <= 9'h000;
			bitCount_reg <= 4'h0;
			stopCount_reg <= 1'b0;
			serialOut_reg <= 1'b1;
		end
		else if (!txActive || disableEvent)
		begin
			// Leaving the active state resets the transmitter at once.
			txState_reg <= uart_pkg::TX_IDLE;
			bitCount_reg <= 4'h0;
			stopCount_reg <= 1'b0;
			serialOut_reg <= 1'b1;
		end
		else
		begin
			case (txState_reg)
				uart_pkg::TX_IDLE:
				begin
					serialOut_reg <= 1'b1;
					if (loadShifter)
					begin
						txShift_reg <= frameBits;
						serialOut_reg <= 1'b0;
						txState_reg <= uart_pkg::TX_START;
					end
				end
				uart_pkg::TX_START:
					if (bitStrobe)
					begin
						serialOut_reg <= txShift_reg[0];
						txShift_reg <= {1'b0, txShift_reg[8:1]};
						bitCount_reg <= 4'h1;
						txState_reg <= uart_pkg::TX_DATA;
					end
				uart_pkg::TX_DATA:
					if (bitStrobe)
					begin
						if (bitCount_reg == dataBitCount)
						begin
							serialOut_reg <= 1'b1;
							stopCount_reg <= ctrlRegOne_reg[uart_pkg::CR1_STOP_COUNT];
							txState_reg <= uart_pkg::TX_STOP;
						end
						else
						begin
							serialOut_reg <= txShift_reg[0];
							txShift_reg <= {1'b0, txShift_reg[8:1]};
							bitCount_reg <= bitCount_reg + 4'h1;
						end
					end
				uart_pkg::TX_STOP:
					if (bitStrobe)
					begin
						if (stopCount_reg)
							stopCount_reg <= 1'b0;
						else if (holdingFull_reg)
						begin
							// Next byte enters the shifter only after the stop bit.
							txShift_reg <= frameBits;
							serialOut_reg <= 1'b0;
							txState_reg <= uart_pkg::TX_START;
						end
						else
							txState_reg <= uart_pkg::TX_IDLE;
					end
				default:
					txState_reg <= uart_pkg::TX_IDLE;
			endcase
		end
	end

	// The output is driven only while the transmitter owns it, else it floats.
	assign serialOutPin = txActive ? serialOut_reg : 1'b1;
	assign serialOutEnable = txActive;
	// Input pin ownership follows mode, port and receive enables.
	assign serialInOwned = serialModeOn && portEnable && ctrlRegTwo_reg[uart_pkg::CR2_RX_ENABLE] &&
		(serialInPin || !serialInPin);
	assign rxEnabled = portEnable && ctrlRegTwo_reg[uart_pkg::CR2_RX_ENABLE];

endmodule : uart_tx_port

// >>> dv/uart_tx_port_assertions.sv
// Checker for bus timing, pin ownership and line framing of the serial port.
`timescale 1ns/1ps

module uart_tx_port_assertions #(
	parameter int DIV_WIDTH = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic serialOutPin,
	input wire logic serialOutEnable,
	input wire logic serialInPin,
	input wire logic serialInOwned,
	input wire logic rxEnabled
);
	// Shadow control bits, updated on the edge at which a write is taken.
	logic portEn;
	logic txEn;
	logic rxEn;
	logic modeOn;
	logic speed;
	logic [7:0] div;
	// Cycles the output has been low so far; a low run that ends with the output still enabled is never shorter than a bit.
	int lowRun;
	int bitLen;
	logic outExp;
	logic rxExp;

	assign bitLen = (int'(div) + 1) * (speed ? 16 : 64);
	assign outExp = modeOn && portEn && txEn;
	assign rxExp = portEn && rxEn;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// Clearing port enable drops both direction enables, as the port does.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			{portEn, txEn, rxEn, modeOn, speed} <= 5'h00;
			div <= 8'h00;
		end
		else if (write && !waitrequest)
		begin
			case (address)
				uart_pkg::OFS_CTRL_ONE:
				begin
					portEn <= writedata[uart_pkg::CR1_PORT_ENABLE];
					if (!writedata[uart_pkg::CR1_PORT_ENABLE])
					begin
						txEn <= 1'b0;
						rxEn <= 1'b0;
					end
				end
				uart_pkg::OFS_CTRL_TWO:
				begin
					// While the port is off the direction enables stay cleared.
					txEn <= writedata[uart_pkg::CR2_TX_ENABLE] && portEn;
					rxEn <= writedata[uart_pkg::CR2_RX_ENABLE] && portEn;
					speed <= writedata[uart_pkg::CR2_SPEED_SELECT];
				end
				uart_pkg::OFS_DIVISOR: div <= writedata[7:0];
				uart_pkg::OFS_MODE: modeOn <= (writedata[7:0] == uart_pkg::SERIAL_MODE_PORT);
				default: ;
			endcase
		end
	end

	// Low-run counter on the serial output.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			lowRun <= 0;
		else if (serialOutPin)
			lowRun <= 0;
		else
			lowRun <= lowRun + 1;
	end

	wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("Bus request not answered after one cycle.");
	out_owner_a: assert property ($stable(outExp) |-> serialOutEnable == outExp)
		else $error("Output enable disagrees with mode and enables.");
	rx_owner_a: assert property ($stable(rxExp) |-> rxEnabled == rxExp)
		else $error("Receive enable disagrees with control bits.");
	in_owner_a: assert property ($stable(rxExp && modeOn) |-> serialInOwned == (rxExp && modeOn))
		else $error("Input ownership disagrees with mode and enables.");
	unmapped_zero_a: assert property (
		read && !waitrequest && address > uart_pkg::OFS_MODE |-> readdata == uart_pkg::UNMAPPED_READ)
		else $error("Unmapped read returned nonzero data.");
	status_off_a: assert property (
		read && !waitrequest && address == uart_pkg::OFS_STATUS && !portEn |->
		readdata[7:0] == uart_pkg::STATUS_RESET)
		else $error("Status flags wrong while port is off.");
	start_gate_a: assert property ($fell(serialOutPin) |-> serialOutEnable)
		else $error("Frame started without transmit enabled.");
	idle_high_a: assert property (!serialOutEnable |-> serialOutPin)
		else $error("Released output not at idle level.");
	bit_len_a: assert property (
		$rose(serialOutPin) && $past(serialOutEnable) && serialOutEnable |-> lowRun >= bitLen)
		else $error("Low level on the line shorter than one bit time.");
endmodule : uart_tx_port_assertions

bind uart_tx_port uart_tx_port_assertions #(.DIV_WIDTH(DIV_WIDTH)) uart_tx_port_assertions_inst (
	.clk(clk), .reset(reset), .address(address), .read(read), .write(write), .writedata(writedata),
	.readdata(readdata), .waitrequest(waitrequest), .serialOutPin(serialOutPin),
	.serialOutEnable(serialOutEnable), .serialInPin(serialInPin), .serialInOwned(serialInOwned),
	.rxEnabled(rxEnabled)
);

// >>> dv/line_partner.sv
// Behavioural remote receiver decoding frames from the serial output line.
`timescale 1ns/1ps

module line_partner (
	input wire logic clk,
	input wire logic serialOutPin,
	input wire logic serialOutEnable,
	input wire logic [15:0] bitLen,
	input wire logic [3:0] nBits,
	output logic serialInPin,
	output logic [8:0] word,
	output logic stopOk,
	output int frames
);
	logic lineLevel;
	logic [8:0] shiftIn;
	logic intact;

	// A released output floats to the pull-up level.
	assign lineLevel = serialOutEnable ? serialOutPin : 1'b1;

	// Nothing is sent back, so the return line idles high.
	initial serialInPin = 1'b1;

	// Hunt a start bit, sample mid-bit LSB first, then the stop bit; aborted frames are dropped.
	initial
	begin
		frames = 0;
		word = 9'h000;
		stopOk = 1'b0;
		forever
		begin
			@(posedge clk);
			if (lineLevel === 1'b0)
			begin
				shiftIn = 9'h000;
				repeat (bitLen / 2) @(posedge clk);
				intact = (lineLevel === 1'b0);
				for (int i = 0; i < nBits; i++)
				begin
					repeat (bitLen) @(posedge clk);
					shiftIn[i] = lineLevel;
					intact = intact && serialOutEnable;
				end
				repeat (bitLen) @(posedge clk);
				if (intact && serialOutEnable)
				begin
					word = shiftIn;
					stopOk = (lineLevel === 1'b1);
					frames++;
				end
			end
		end
	end
endmodule : line_partner

// >>> dv/testbench.sv
// Self-checking bench driving the serial port over its register bus.
`timescale 1ns/1ps

module testbench;
	logic clk = 1'b0;
	logic reset;
	logic [3:0] address;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic waitrequest;
	logic serialOutPin;
	logic serialOutEnable;
	logic serialInPin;
	logic serialInOwned;
	logic rxEnabled;
	logic [15:0] bitLen;
	logic [3:0] nBits;
	logic [8:0] word;
	logic stopOk;
	int frames;
	int n_fail = 0;
	int checked = 0;
	int base;
	logic [31:0] rd;
	// Format table: control one, control two, divisor, data byte.
	logic [7:0] fmt [0:5][0:3] = '{'{8'h80, 8'ha0, 8'h01, 8'ha5}, '{8'h80, 8'h80, 8'h00, 8'h96},
		'{8'hc1, 8'hf0, 8'h02, 8'h5a}, '{8'ha0, 8'ha0, 8'h01, 8'h07}, '{8'hb8, 8'ha0, 8'h01, 8'h07},
		'{8'he0, 8'ha0, 8'h01, 8'h07}};

	always #5 clk = ~clk;

	uart_tx_port uart_tx_port_inst (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .serialOutPin(serialOutPin),
		.serialOutEnable(serialOutEnable), .serialInPin(serialInPin), .serialInOwned(serialInOwned),
		.rxEnabled(rxEnabled));

	line_partner line_partner_inst (.clk(clk), .serialOutPin(serialOutPin), .serialOutEnable(serialOutEnable),
		.bitLen(bitLen), .nBits(nBits), .serialInPin(serialInPin), .word(word), .stopOk(stopOk), .frames(frames));

	// Expected word on the line: the ninth bit or parity takes the last position.
	function automatic logic [8:0] expect_word(input logic [7:0] c, input logic [7:0] d);
		logic [8:0] w;
		int nb;
		nb = c[uart_pkg::CR1_NINE_BIT] ? 9 : 8;
		w = c[uart_pkg::CR1_NINE_BIT] ? {c[uart_pkg::CR1_TX_BIT_NINE], d} : {1'b0, d};
		if (c[uart_pkg::CR1_PARITY_ENABLE])
		begin
			w[nb - 1] = 1'b0;
			w[nb - 1] = (^w) ^ c[uart_pkg::CR1_PARITY_TYPE];
		end
		return w;
	endfunction : expect_word

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Request held until waitrequest is sampled low at a rising edge.
	task bus_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		address <= a;
		writedata <= {24'h00_0000, d};
		write <= 1'b1;
		do @(posedge clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask : bus_write

	task read_check(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		address <= a;
		read <= 1'b1;
		do @(posedge clk); while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		check("register read", rd, {24'h00_0000, exp});
	endtask : read_check

	// Waits for the partner to finish a frame and compares it.
	task frame_check(input int target, input logic [7:0] c, input logic [7:0] d);
		while (frames < target) @(posedge clk);
		check("line word", {23'h00_0000, word}, {23'h00_0000, expect_word(c, d)});
		check("stop bit", {31'h0000_0000, stopOk}, 32'h0000_0001);
		repeat (bitLen * 2) @(posedge clk);
	endtask : frame_check

	task end_of_test;
		$display("Checks %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	// Watchdog cuts a hung run short.
	initial
	begin
		repeat (60000) @(posedge clk);
		n_fail++;
		$display("[ERR] watchdog expected finish seen timeout");
		end_of_test;
	end

	initial
	begin
		reset = 1'b1;
		{read, write} = 2'b00;
		address = 4'h0;
		writedata = 32'h0000_0000;
		{bitLen, nBits} = {16'h0020, 4'h8};
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		read_check(uart_pkg::OFS_CTRL_ONE, uart_pkg::CR1_RESET);
		read_check(uart_pkg::OFS_CTRL_TWO, uart_pkg::CR2_RESET);
		read_check(uart_pkg::OFS_STATUS, uart_pkg::STATUS_RESET);
		bus_write(4'hf, 8'hff);
		read_check(4'hf, 8'h00);
		bus_write(uart_pkg::OFS_MODE, uart_pkg::SERIAL_MODE_PORT);
		// Every format, both speeds, ninth bit, address detect and both parities.
		for (int i = 0; i < 6; i++)
		begin
			bus_write(uart_pkg::OFS_CTRL_ONE, fmt[i][0]);
			bus_write(uart_pkg::OFS_DIVISOR, fmt[i][2]);
			bus_write(uart_pkg::OFS_CTRL_TWO, fmt[i][1]);
			bitLen = (16'(fmt[i][2]) + 16'h0001) * (fmt[i][1][5] ? 16'h0010 : 16'h0040);
			nBits = fmt[i][0][6] ? 4'h9 : 4'h8;
			bus_write(uart_pkg::OFS_DATA, fmt[i][3]);
			frame_check(frames + 1, fmt[i][0], fmt[i][3]);
		end
		// Second byte waits in the holding register until the first stop bit.
		base = frames;
		bus_write(uart_pkg::OFS_DATA, 8'h3c);
		bus_write(uart_pkg::OFS_DATA, 8'hc3);
		frame_check(base + 1, 8'he0, 8'h3c);
		frame_check(base + 2, 8'he0, 8'hc3);
		// Data loaded first, transmission begins only once transmit is enabled.
		bus_write(uart_pkg::OFS_CTRL_TWO, 8'h20);
		bus_write(uart_pkg::OFS_DATA, 8'h55);
		repeat (bitLen * 12) @(posedge clk);
		check("frames held", frames, base + 2);
		bus_write(uart_pkg::OFS_CTRL_TWO, 8'ha0);
		frame_check(base + 3, 8'he0, 8'h55);
		// Transmit disable mid-frame releases the pin and drops the frame.
		bus_write(uart_pkg::OFS_DATA, 8'h00);
		repeat (bitLen * 3) @(posedge clk);
		bus_write(uart_pkg::OFS_CTRL_TWO, 8'h20);
		// The write lands at the answer edge, so the released pin is seen one edge later.
		@(posedge clk);
		check("output enable", {31'h0000_0000, serialOutEnable}, 32'h0000_0000);
		repeat (bitLen * 12) @(posedge clk);
		check("frames aborted", frames, base + 3);
		// Port disable mid-frame with a byte pending; format survives, buffer does not.
		bus_write(uart_pkg::OFS_CTRL_TWO, 8'ha0);
		bus_write(uart_pkg::OFS_DATA, 8'h00);
		repeat (bitLen * 3) @(posedge clk);
		bus_write(uart_pkg::OFS_DATA, 8'hff);
		bus_write(uart_pkg::OFS_CTRL_ONE, 8'h60);
		read_check(uart_pkg::OFS_CTRL_TWO, 8'h20);
		read_check(uart_pkg::OFS_DIVISOR, 8'h01);
		read_check(uart_pkg::OFS_CTRL_ONE, 8'h60);
		read_check(uart_pkg::OFS_STATUS, uart_pkg::STATUS_RESET);
		bus_write(uart_pkg::OFS_CTRL_ONE, 8'he0);
		bus_write(uart_pkg::OFS_CTRL_TWO, 8'ha0);
		repeat (bitLen * 24) @(posedge clk);
		check("frames discarded", frames, base + 3);
		bus_write(uart_pkg::OFS_DATA, 8'h81);
		frame_check(base + 4, 8'he0, 8'h81);
		end_of_test;
	end
endmodule : testbench
